/* hw/chan_if.sv */
// Interface between the port top and one channel framer.
// Assumes both ends run on the main clock.
`timescale 1ns/1ps
interface chan_if;
    import conv_io_pkg::*;
    logic              up;
    logic              early_en;
    logic              iq_mux;
    logic              word_en;
    logic              resync;
    logic [FLEN_W-1:0] flen;
    logic [LEAD_W-1:0] lead;
    logic              fs;
    logic              iq;
    modport ctl  (output up, early_en, iq_mux, word_en, resync, flen, lead,
                  input fs, iq);
    modport chan (input up, early_en, iq_mux, word_en, resync, flen, lead,
                  output fs, iq);
endinterface : chan_if

/* hw/conv_chan_frame.sv */
// Per-channel word counter, frame strobe and I/Q slot flag.
// Assumes word_en pulses at most every second main clock cycle.
`timescale 1ns/1ps
module conv_chan_frame
    import conv_io_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    chan_if.chan     bus
);
    logic [FLEN_W-1:0] cnt_q;
    logic [FLEN_W-1:0] cnt_nxt;
    logic [FLEN_W-1:0] cnt_d;
    logic [FLEN_W-1:0] target;
    logic              wrap;
    logic              early_use;
    logic              first_word;
    logic              fs_q;
    logic              fs_d;
    logic              iq_q;
    logic              iq_d;

    // Word index decode; counter parks at all ones after reset
    assign wrap       = (cnt_q >= bus.flen);
    assign cnt_nxt    = wrap ? '0 : cnt_q + 8'h01;
    assign cnt_d      = bus.resync ? bus.flen : (bus.word_en ? cnt_nxt : cnt_q);
    assign first_word = bus.word_en && !bus.resync && (cnt_nxt == '0);
    // Early lead longer than the frame is ignored
    assign early_use  = bus.early_en && (bus.lead != '0) && ({4'h0, bus.lead} <= bus.flen);
    assign target     = early_use ? bus.flen - {4'h0, bus.lead} + 8'h01 : '0;
    assign fs_d       = bus.word_en && !bus.resync && (cnt_nxt == target);
    // I slot first, Q slot flagged high
    assign iq_d       = bus.word_en ? ((first_word || !(bus.up && bus.iq_mux)) ? 1'b0 : ~iq_q)
                                    : iq_q;

    // State registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= CNT_RST;
            fs_q  <= 1'b0;
            iq_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            fs_q  <= fs_d;
            iq_q  <= iq_d;
        end
    end

    assign bus.fs = fs_q;
    assign bus.iq = iq_q;

    // ******************************
    // Checks
    // ******************************
    sequence s_first_word;
        first_word && !early_use;
    endsequence

    property p_fs_first;
        @(posedge clk) disable iff (!rst_b) s_first_word |=> fs_q;
    endproperty
    a_fs_first: assert property (p_fs_first) else $error("strobe missed first word");

    property p_fs_single;
        @(posedge clk) disable iff (!rst_b) fs_q |=> !fs_q;
    endproperty
    a_fs_single: assert property (p_fs_single) else $error("strobe longer than one cycle");

    property p_iq_first;
        @(posedge clk) disable iff (!rst_b) first_word |=> !iq_q;
    endproperty
    a_iq_first: assert property (p_iq_first) else $error("frame does not open on I");

    property p_resync;
        @(posedge clk) disable iff (!rst_b) bus.resync |=> (cnt_q == $past(bus.flen));
    endproperty
    a_resync: assert property (p_resync) else $error("sync did not realign frame");
endmodule : conv_chan_frame

/* hw/conv_io_pkg.sv */
// Shared constants for the converter port framing block.
// Assumes one 50 MHz main clock and a 5-bit register port.
package conv_io_pkg;
    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 5;
    localparam int          NCHAN           = 4;
    localparam int          FLEN_W          = 8;
    localparam int          LEAD_W          = 4;
    localparam int          DIV_W           = 4;
    localparam int          IR_W            = 2;
    // Register offsets
    localparam logic [4:0]  ADDR_CONFIG     = 5'h00;
    localparam logic [4:0]  ADDR_FRAME_LEN  = 5'h01;
    localparam logic [4:0]  ADDR_EARLY_LEAD = 5'h02;
    localparam logic [4:0]  ADDR_CLK_DIV    = 5'h03;
    localparam logic [4:0]  ADDR_STATUS     = 5'h04;
    // Config field positions
    localparam int          CFG_UP_LSB      = 0;
    localparam int          CFG_XCVR_BIT    = 4;
    localparam int          CFG_SUM_C_BIT   = 5;
    localparam int          CFG_SUM_D_BIT   = 6;
    localparam int          CFG_IQMUX_BIT   = 7;
    localparam int          CFG_EARLY_BIT   = 8;
    localparam int          CFG_SYNC_SW_BIT = 9;
    // Reset values and the transceiver direction map
    localparam logic [15:0] CONFIG_RST      = 16'h0000;
    localparam logic [7:0]  FRAME_LEN_RST   = 8'h07;
    localparam logic [3:0]  LEAD_RST        = 4'h1;
    localparam logic [3:0]  CLK_DIV_RST     = 4'h1;
    localparam logic [7:0]  CNT_RST         = 8'hff;
    localparam logic [3:0]  XCVR_UP_MAP     = 4'h3;
    // Test access codes
    localparam logic [1:0]  IR_CAPTURE      = 2'h1;
    localparam logic [1:0]  IR_BYPASS       = 2'h3;
    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR,
        TS_PAU_DR, TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR,
        TS_EX1_IR, TS_PAU_IR, TS_EX2_IR, TS_UPD_IR
    } tap_state_t;
endpackage : conv_io_pkg

/* hw/conv_port_io.sv */
// Top of the converter port framing block: pins, registers, test port.
// Assumes data, sum, sync, scan and select pins are asynchronous to CLK and synchronises them; the register port is used as is.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
// Functional notes
// - Four 16-bit clocked input ports A-D
// - Clocked output ports A and B
// - C/D pins: output or sum input
// - Port clock per port, clocks words
// - Transceiver: A,B up; C,D down
// - Frame strobe high with first word
// - Optional early frame strobe
// - I/Q flag in multiplexed up-conversion
// - Chip reset active low, asynchronous
// - Two active-low sync inputs, idle high
// - Active-low clocked sync output
// - Scan inputs sampled on test clock rise
// - Scan output on fall, else released
// - Scan logic reset by test reset
// - All clocked pins timed on CLK rise
// - I slot precedes Q slot
// - Bit 0 is least significant
module conv_port_io
    import conv_io_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_B,
    input  wire logic [DATA_W-1:0] PORT_A_IN,
    input  wire logic [DATA_W-1:0] PORT_B_IN,
    input  wire logic [DATA_W-1:0] PORT_C_IN,
    input  wire logic [DATA_W-1:0] PORT_D_IN,
    output logic      [DATA_W-1:0] PORT_A_OUT,
    output logic      [DATA_W-1:0] PORT_B_OUT,
    input  wire logic [DATA_W-1:0] PORT_C_OUT_OR_SUM_IN_I,
    output logic      [DATA_W-1:0] PORT_C_OUT_OR_SUM_IN_O,
    output logic      [DATA_W-1:0] PORT_C_OUT_OR_SUM_IN_OE,
    input  wire logic [DATA_W-1:0] PORT_D_OUT_OR_SUM_IN_I,
    output logic      [DATA_W-1:0] PORT_D_OUT_OR_SUM_IN_O,
    output logic      [DATA_W-1:0] PORT_D_OUT_OR_SUM_IN_OE,
    output logic      [NCHAN-1:0]  PORT_CLK_OUT,
    output logic      [NCHAN-1:0]  FRAME_START_STROBE,
    output logic                   IQ_PHASE_FLAG,
    input  wire logic              SYNC_IN_A_N,
    input  wire logic              SYNC_IN_B_N,
    output logic                   SYNC_OUT_N,
    input  wire logic              WRITE_LATCH_TIMING_SEL,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    input  wire logic              TCK,
    input  wire logic              TDI,
    input  wire logic              TMS,
    input  wire logic              TRST_N,
    output logic                   TDO,
    output logic                   TDO_OE
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [DATA_W-1:0] in_pin [NCHAN];
    logic [DATA_W-1:0] in_m_q [NCHAN];
    logic [DATA_W-1:0] in_s_q [NCHAN];
    logic [DATA_W-1:0] sum_m_q [2];
    logic [DATA_W-1:0] sum_s_q [2];
    logic [5:0]        ctl_m_q;
    logic [5:0]        ctl_s_q;
    logic              tck_old_q;
    logic [DATA_W-1:0] out_q [NCHAN];

    assign in_pin[0] = PORT_A_IN;
    assign in_pin[1] = PORT_B_IN;
    assign in_pin[2] = PORT_C_IN;
    assign in_pin[3] = PORT_D_IN;

    // Two stages per data pin; first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < NCHAN; gi++) begin : g_in_sync
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    in_m_q[gi] <= '0;
                    in_s_q[gi] <= '0;
                end else begin
                    in_m_q[gi] <= in_pin[gi];
                    in_s_q[gi] <= in_m_q[gi];
                end
            end
        end
    endgenerate

    // Sum inputs, control levels and the test clock
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sum_m_q[0] <= '0;
            sum_m_q[1] <= '0;
            sum_s_q[0] <= '0;
            sum_s_q[1] <= '0;
            ctl_m_q    <= 6'h3f;
            ctl_s_q    <= 6'h3f;
            tck_old_q  <= 1'b1;
        end else begin
            sum_m_q[0] <= PORT_C_OUT_OR_SUM_IN_I;
            sum_m_q[1] <= PORT_D_OUT_OR_SUM_IN_I;
            sum_s_q[0] <= sum_m_q[0];
            sum_s_q[1] <= sum_m_q[1];
            ctl_m_q    <= {TCK, WRITE_LATCH_TIMING_SEL, TMS, TDI, SYNC_IN_B_N, SYNC_IN_A_N};
            ctl_s_q    <= ctl_m_q;
            tck_old_q  <= ctl_s_q[5];
        end
    end

    // ****************************************
    // Register port
    // ****************************************
    logic [15:0]       config_q;
    logic [FLEN_W-1:0] flen_q;
    logic [LEAD_W-1:0] lead_q;
    logic [DIV_W-1:0]  div_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] status_w;
    logic [NCHAN-1:0]  up_map;
    logic              wr_cfg;
    logic              sw_sync;
    logic              sum_c_en;
    logic              sum_d_en;

    // Transceiver overrides the per-channel direction bits
    assign up_map   = config_q[CFG_XCVR_BIT] ? XCVR_UP_MAP
                                             : config_q[CFG_UP_LSB +: NCHAN];
    assign sum_c_en = config_q[CFG_SUM_C_BIT];
    assign sum_d_en = config_q[CFG_SUM_D_BIT];
    assign wr_cfg   = WR && (ADDR == ADDR_CONFIG);
    // Software sync is a self-clearing write bit
    assign sw_sync  = wr_cfg && WDATA[CFG_SYNC_SW_BIT];
    assign status_w = {4'h0, up_map, ctl_s_q[4], ctl_s_q[1], ctl_s_q[0],
                       IQ_PHASE_FLAG, FRAME_START_STROBE};
    // Unmapped addresses read as zero
    assign rd_mux   = (ADDR == ADDR_CONFIG)     ? config_q :
                      (ADDR == ADDR_FRAME_LEN)  ? {8'h00, flen_q} :
                      (ADDR == ADDR_EARLY_LEAD) ? {12'h000, lead_q} :
                      (ADDR == ADDR_CLK_DIV)    ? {12'h000, div_q} :
                      (ADDR == ADDR_STATUS)     ? status_w : '0;

    // Writes; read data is valid only in the cycle after RD
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            config_q <= CONFIG_RST;
            flen_q   <= FRAME_LEN_RST;
            lead_q   <= LEAD_RST;
            div_q    <= CLK_DIV_RST;
            rdata_q  <= '0;
        end else begin
            if (wr_cfg) config_q <= WDATA & ~(16'h0001 << CFG_SYNC_SW_BIT);
            if (WR && ADDR == ADDR_FRAME_LEN)  flen_q <= WDATA[FLEN_W-1:0];
            if (WR && ADDR == ADDR_EARLY_LEAD) lead_q <= WDATA[LEAD_W-1:0];
            if (WR && ADDR == ADDR_CLK_DIV)    div_q  <= WDATA[DIV_W-1:0];
            rdata_q <= RD ? rd_mux : '0;
        end
    end

    // ****************************************
    // Port clock divider and word timing
    // ****************************************
    logic [DIV_W-1:0] div_cnt_q;
    logic             pclk_q;
    logic             div_tc;
    logic             word_en;

    // Words launch as the port clock falls, so the far side samples on rise
    assign div_tc  = (div_cnt_q >= div_q);
    assign word_en = div_tc && pclk_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            div_cnt_q <= '0;
            pclk_q    <= 1'b0;
        end else begin
            div_cnt_q <= div_tc ? '0 : div_cnt_q + 4'h1;
            if (div_tc) pclk_q <= ~pclk_q;
        end
    end

    // ****************************************
    // Channels and data ports
    // ****************************************
    chan_if ch [NCHAN] ();
    logic [NCHAN-1:0] fs_w;
    logic [NCHAN-1:0] iq_w;
    logic [NCHAN-1:0] resync_w;
    logic             sync_out_n_q;

    // Sync A realigns A,B; sync B realigns C,D; software hits all
    assign resync_w = {{2{!ctl_s_q[1]}}, {2{!ctl_s_q[0]}}} | {NCHAN{sw_sync}};

    generate
        for (gi = 0; gi < NCHAN; gi++) begin : g_chan
            assign ch[gi].up       = up_map[gi];
            assign ch[gi].early_en = config_q[CFG_EARLY_BIT];
            assign ch[gi].iq_mux   = config_q[CFG_IQMUX_BIT];
            assign ch[gi].word_en  = word_en;
            assign ch[gi].resync   = resync_w[gi];
            assign ch[gi].flen     = flen_q;
            assign ch[gi].lead     = lead_q;
            assign fs_w[gi]        = ch[gi].fs;
            assign iq_w[gi]        = ch[gi].iq;
            conv_chan_frame u_frame (
                .clk   (CLK),
                .rst_b (RST_B),
                .bus   (ch[gi])
            );
        end
    endgenerate

    // Output words; A and B add the sum inputs when C/D are turned round
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            out_q[0] <= '0;
            out_q[1] <= '0;
            out_q[2] <= '0;
            out_q[3] <= '0;
        end else if (word_en) begin
            out_q[0] <= in_s_q[0] + (sum_c_en ? sum_s_q[0] : 16'h0000);
            out_q[1] <= in_s_q[1] + (sum_d_en ? sum_s_q[1] : 16'h0000);
            out_q[2] <= in_s_q[2];
            out_q[3] <= in_s_q[3];
        end
    end

    // Pin drivers; enables follow the sum selects with one register stage
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PORT_C_OUT_OR_SUM_IN_OE <= '0;
            PORT_D_OUT_OR_SUM_IN_OE <= '0;
            PORT_CLK_OUT            <= '0;
            sync_out_n_q            <= 1'b1;
        end else begin
            PORT_C_OUT_OR_SUM_IN_OE <= {DATA_W{!sum_c_en}};
            PORT_D_OUT_OR_SUM_IN_OE <= {DATA_W{!sum_d_en}};
            PORT_CLK_OUT            <= {NCHAN{div_tc ? ~pclk_q : pclk_q}};
            sync_out_n_q            <= !(fs_w[0] || sw_sync);
        end
    end

    assign PORT_A_OUT             = out_q[0];
    assign PORT_B_OUT             = out_q[1];
    assign PORT_C_OUT_OR_SUM_IN_O = out_q[2];
    assign PORT_D_OUT_OR_SUM_IN_O = out_q[3];
    assign FRAME_START_STROBE     = fs_w;
    assign IQ_PHASE_FLAG          = iq_w[0];
    assign SYNC_OUT_N             = sync_out_n_q;
    assign RDATA                  = rdata_q;

    // ****************************************
    // Boundary-scan controller
    // ****************************************
    tap_state_t tap_q;
    tap_state_t tap_d;
    logic [IR_W-1:0] ir_q;
    logic            byp_q;
    logic            tdo_q;
    logic            tdo_oe_q;
    logic            tck_rise;
    logic            tck_fall;
    logic            tms_s;
    logic            tdi_s;
    logic            shifting;

    // Edges seen by CLK; a slow test clock is assumed
    assign tck_rise = ctl_s_q[5] && !tck_old_q;
    assign tck_fall = !ctl_s_q[5] && tck_old_q;
    assign tms_s    = ctl_s_q[3];
    assign tdi_s    = ctl_s_q[2];
    assign shifting = (tap_q == TS_SH_DR) || (tap_q == TS_SH_IR);

    // Standard controller walk
    always_comb begin
        tap_d = tap_q;
        case (tap_q)
            TS_RESET:  tap_d = tms_s ? TS_RESET  : TS_IDLE;
            TS_IDLE:   tap_d = tms_s ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: tap_d = tms_s ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: tap_d = tms_s ? TS_EX1_DR : TS_SH_DR;
            TS_SH_DR:  tap_d = tms_s ? TS_EX1_DR : TS_SH_DR;
            TS_EX1_DR: tap_d = tms_s ? TS_UPD_DR : TS_PAU_DR;
            TS_PAU_DR: tap_d = tms_s ? TS_EX2_DR : TS_PAU_DR;
            TS_EX2_DR: tap_d = tms_s ? TS_UPD_DR : TS_SH_DR;
            TS_SEL_IR: tap_d = tms_s ? TS_RESET  : TS_CAP_IR;
            TS_CAP_IR: tap_d = tms_s ? TS_EX1_IR : TS_SH_IR;
            TS_SH_IR:  tap_d = tms_s ? TS_EX1_IR : TS_SH_IR;
            TS_EX1_IR: tap_d = tms_s ? TS_UPD_IR : TS_PAU_IR;
            TS_PAU_IR: tap_d = tms_s ? TS_EX2_IR : TS_PAU_IR;
            TS_EX2_IR: tap_d = tms_s ? TS_UPD_IR : TS_SH_IR;
            TS_UPD_DR: tap_d = tms_s ? TS_SEL_DR : TS_IDLE;
            TS_UPD_IR: tap_d = tms_s ? TS_SEL_DR : TS_IDLE;
            default:   tap_d = TS_RESET;
        endcase
    end

    // Rise: state and shift registers; only bypass is implemented
    always_ff @(posedge CLK or negedge TRST_N) begin
        if (!TRST_N) begin
            tap_q <= TS_RESET;
            ir_q  <= IR_BYPASS;
            byp_q <= 1'b0;
        end else if (tck_rise) begin
            tap_q <= tap_d;
            if (tap_q == TS_CAP_IR) ir_q <= IR_CAPTURE;
            if (tap_q == TS_SH_IR)  ir_q <= {tdi_s, ir_q[IR_W-1:1]};
            if (tap_q == TS_CAP_DR) byp_q <= 1'b0;
            if (tap_q == TS_SH_DR)  byp_q <= tdi_s;
        end
    end

    // Fall: output bit and its enable
    always_ff @(posedge CLK or negedge TRST_N) begin
        if (!TRST_N) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q    <= (tap_q == TS_SH_IR) ? ir_q[0] : byp_q;
            tdo_oe_q <= shifting;
        end
    end

    assign TDO    = tdo_q;
    assign TDO_OE = tdo_oe_q;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_word;
        word_en;
    endsequence

    property p_c_dir;
        @(posedge CLK) disable iff (!RST_B)
            sum_c_en |=> (PORT_C_OUT_OR_SUM_IN_OE == '0);
    endproperty
    a_c_dir: assert property (p_c_dir) else $error("C pins driven in sum mode");

    property p_pclk_fall;
        @(posedge CLK) disable iff (!RST_B) s_word |=> !PORT_CLK_OUT[0];
    endproperty
    a_pclk_fall: assert property (p_pclk_fall) else $error("word not on clock fall");

    property p_xcvr;
        @(posedge CLK) disable iff (!RST_B)
            config_q[CFG_XCVR_BIT] |-> (up_map == XCVR_UP_MAP);
    endproperty
    a_xcvr: assert property (p_xcvr) else $error("transceiver direction wrong");

    property p_out_hold;
        @(posedge CLK) disable iff (!RST_B)
            !word_en |=> $stable(PORT_B_OUT);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("port B moved off word");

    property p_sync_pulse;
        @(posedge CLK) disable iff (!RST_B) $fell(SYNC_OUT_N) |=> SYNC_OUT_N;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("sync out too long");

    property p_iq_toggle;
        @(posedge CLK) disable iff (!RST_B)
            (word_en && up_map[0] && config_q[CFG_IQMUX_BIT] && IQ_PHASE_FLAG)
            |=> !IQ_PHASE_FLAG;
    endproperty
    a_iq_toggle: assert property (p_iq_toggle) else $error("Q slot not followed by I");

    property p_tap_edge;
        @(posedge CLK) disable iff (!TRST_N) !tck_rise |=> $stable(tap_q);
    endproperty
    a_tap_edge: assert property (p_tap_edge) else $error("scan state off rising edge");

    property p_tdo_edge;
        @(posedge CLK) disable iff (!TRST_N)
            !tck_fall |=> ($stable(tdo_q) && $stable(tdo_oe_q));
    endproperty
    a_tdo_edge: assert property (p_tdo_edge) else $error("scan output off falling edge");
endmodule : conv_port_io

/* testbench/conv_far_model.sv */
// Far-side model: data converters on ports A-D and a summing chip on C/D.
// Assumes the bench ties these outputs straight to the block's pins.
`timescale 1ns/1ps
module conv_far_model
    import conv_io_pkg::*;
#(
    parameter logic [DATA_W-1:0] WA = 16'h1234,
    parameter logic [DATA_W-1:0] WB = 16'h00ff,
    parameter logic [DATA_W-1:0] WC = 16'h8001,
    parameter logic [DATA_W-1:0] WD = 16'h0040,
    parameter logic [DATA_W-1:0] SC = 16'h0011,
    parameter logic [DATA_W-1:0] SD = 16'h0022
)
(
    input  wire logic [DATA_W-1:0] c_o,
    input  wire logic [DATA_W-1:0] c_oe,
    input  wire logic [DATA_W-1:0] d_o,
    input  wire logic [DATA_W-1:0] d_oe,
    output logic      [DATA_W-1:0] a_in,
    output logic      [DATA_W-1:0] b_in,
    output logic      [DATA_W-1:0] c_in,
    output logic      [DATA_W-1:0] d_in,
    output logic      [DATA_W-1:0] c_pin,
    output logic      [DATA_W-1:0] d_pin
);
    // Steady words, so a check need not know which word slot it samples
    assign a_in = WA;
    assign b_in = WB;
    assign c_in = WC;
    assign d_in = WD;
    // Pin level per bit: the block's drive wins, else the summing chip
    assign c_pin = (c_oe & c_o) | (~c_oe & SC);
    assign d_pin = (d_oe & d_o) | (~d_oe & SD);
endmodule : conv_far_model

/* testbench/conv_port_io_test.sv */
// Self-checking bench for the converter port framing block.
// Assumes the far-side model supplies constant port words.
`timescale 1ns/1ps
module conv_port_io_test;
    import conv_io_pkg::*;
    localparam logic [15:0] WA = 16'h1234, WB = 16'h00ff, WC = 16'h8001, WD = 16'h0040;
    localparam logic [15:0] SC = 16'h0011, SD = 16'h0022;
    typedef struct {logic wr; logic [4:0] a; logic [15:0] d; logic [15:0] e;} row_t;
    logic        CLK = 0, RST_B = 0, WR = 0, RD = 0, SYNC_IN_A_N = 1, TRST_N = 0;
    logic        TCK = 1, TDI = 1, TMS = 1;
    logic [4:0]  ADDR = '0;
    logic [15:0] WDATA = '0, RDATA, A_IN, B_IN, C_IN, D_IN, A_OUT, B_OUT;
    logic [15:0] C_I, C_O, C_OE, D_I, D_O, D_OE;
    logic [3:0]  PCLK, FS;
    logic        IQ, SYNC_OUT_N, TDO, TDO_OE;
    int          err_total = 0, num_checks = 0, n;
    // Ordinary cases: optional write, then read-back expectation
    row_t rows[7] = '{'{0, 5'h00, 0, 16'h0000}, '{0, 5'h01, 0, 16'h0007},
        '{0, 5'h02, 0, 16'h0001}, '{0, 5'h03, 0, 16'h0001}, '{1, 5'h1f, 16'hffff, 16'h0000},
        '{1, 5'h02, 16'h0003, 16'h0003}, '{1, 5'h00, 16'h0200, 16'h0000}};
    always #10 CLK = ~CLK;
    conv_far_model #(.WA(WA), .WB(WB), .WC(WC), .WD(WD), .SC(SC), .SD(SD)) i_conv_far_model (
        .c_o(C_O), .c_oe(C_OE), .d_o(D_O), .d_oe(D_OE), .a_in(A_IN), .b_in(B_IN),
        .c_in(C_IN), .d_in(D_IN), .c_pin(C_I), .d_pin(D_I));
    conv_port_io i_conv_port_io (
        .CLK(CLK), .RST_B(RST_B), .PORT_A_IN(A_IN), .PORT_B_IN(B_IN), .PORT_C_IN(C_IN),
        .PORT_D_IN(D_IN), .PORT_A_OUT(A_OUT), .PORT_B_OUT(B_OUT),
        .PORT_C_OUT_OR_SUM_IN_I(C_I), .PORT_C_OUT_OR_SUM_IN_O(C_O),
        .PORT_C_OUT_OR_SUM_IN_OE(C_OE), .PORT_D_OUT_OR_SUM_IN_I(D_I),
        .PORT_D_OUT_OR_SUM_IN_O(D_O), .PORT_D_OUT_OR_SUM_IN_OE(D_OE),
        .PORT_CLK_OUT(PCLK), .FRAME_START_STROBE(FS), .IQ_PHASE_FLAG(IQ),
        .SYNC_IN_A_N(SYNC_IN_A_N), .SYNC_IN_B_N(1'b1), .SYNC_OUT_N(SYNC_OUT_N),
        .WRITE_LATCH_TIMING_SEL(1'b1), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .TCK(TCK), .TDI(TDI), .TMS(TMS), .TRST_N(TRST_N),
        .TDO(TDO), .TDO_OE(TDO_OE));
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk
    // One-cycle strobe; read data is sampled in the cycle after it
    task automatic bus(logic w, logic [4:0] a, logic [15:0] d);
        @(posedge CLK);
        WR <= w;
        RD <= !w;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 0;
        RD <= 0;
        #1;
    endtask : bus
    // Bounded wait for the channel A frame strobe, counting cycles
    task automatic wait_fs(output int k);
        k = 0;
        do begin
            @(posedge CLK);
            #1;
            k++;
        end while (FS[0] !== 1'b1 && k < 100);
    endtask : wait_fs
    // One 160 ns test clock period: low with new TMS/TDI, then high
    task automatic scan(logic ms, logic di);
        TCK <= 0;
        TMS <= ms;
        TDI <= di;
        repeat (4) @(posedge CLK);
        TCK <= 1;
        repeat (4) @(posedge CLK);
        #1;
    endtask : scan
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    initial begin
        #60000;
        err_total++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge CLK);
        RST_B <= 1;
        TRST_N <= 1;
        foreach (rows[i]) begin
            if (rows[i].wr) bus(1, rows[i].a, rows[i].d);
            bus(0, rows[i].a, 16'h0);
            chk("rdata", rows[i].e, RDATA);
        end
        $display("test registers done");
        // Plain ports, then C/D turned round into sum inputs
        repeat (20) @(posedge CLK);
        #1;
        chk("a_out", WA, A_OUT);
        chk("b_out", WB, B_OUT);
        chk("c_oe", 16'hffff, C_OE);
        chk("d_oe", 16'hffff, D_OE);
        chk("c_out", WC, C_O);
        chk("d_out", WD, D_O);
        bus(1, ADDR_CONFIG, 16'h0060);
        repeat (20) @(posedge CLK);
        #1;
        chk("c_oe", 16'h0000, C_OE);
        chk("d_oe", 16'h0000, D_OE);
        chk("a_sum", WA + SC, A_OUT);
        chk("b_sum", WB + SD, B_OUT);
        bus(1, ADDR_CONFIG, 16'h0010);
        bus(0, ADDR_STATUS, 16'h0);
        chk("up_map", 16'h0003, {12'h0, RDATA[11:8]});
        chk("wsel", 16'h0001, {15'h0, RDATA[7]});
        $display("test ports done");
        // Frame of 8 words at 4 cycles each: strobe every 32 cycles
        bus(1, ADDR_CONFIG, 16'h0000);
        wait_fs(n);
        wait_fs(n);
        chk("fs_period", 16'd32, 16'(n));
        chk("fs_all", 16'h000f, {12'h0, FS});
        chk("pclk_fall", 16'h0000, {12'h0, PCLK});
        @(posedge CLK);
        #1;
        chk("fs_width", 16'h0, {12'h0, FS});
        chk("sync_out", 16'h0, {15'h0, SYNC_OUT_N});
        @(posedge CLK);
        #1;
        chk("pclk_rise", 16'h000f, {12'h0, PCLK});
        // Multiplexed I/Q: slot 0 is I, the next word is Q
        bus(1, ADDR_CONFIG, 16'h0081);
        wait_fs(n);
        chk("iq_i", 16'h0, {15'h0, IQ});
        repeat (4) @(posedge CLK);
        #1;
        chk("iq_q", 16'h1, {15'h0, IQ});
        // Early by 3 words lands on index 5, an odd (Q) slot
        bus(1, ADDR_CONFIG, 16'h0181);
        wait_fs(n);
        wait_fs(n);
        chk("early_q", 16'h1, {15'h0, IQ});
        $display("test framing done");
        // Sync A low must restart the frame within 12 cycles, three word periods
        bus(1, ADDR_CONFIG, 16'h0000);
        SYNC_IN_A_N <= 0;
        repeat (2) @(posedge CLK);
        SYNC_IN_A_N <= 1;
        wait_fs(n);
        chk("sync_fs", 16'h1, {15'h0, n <= 12});
        // Scan: idle, select, capture, shift one bit through bypass, exit
        scan(0, 1);
        scan(1, 1);
        scan(0, 1);
        scan(0, 1);
        scan(0, 1);
        chk("tdo_oe", 16'h1, {15'h0, TDO_OE});
        chk("tdo_cap", 16'h0, {15'h0, TDO});
        scan(1, 0);
        chk("tdo_byp", 16'h1, {15'h0, TDO});
        scan(1, 0);
        chk("tdo_off", 16'h0, {15'h0, TDO_OE});
        $display("test scan done");
        // Both resets act at once, without a clock edge
        @(posedge CLK);
        TRST_N <= 0;
        RST_B <= 0;
        #1;
        chk("tdo_oe", 16'h0, {15'h0, TDO_OE});
        chk("a_rst", 16'h0, A_OUT);
        chk("so_rst", 16'h1, {15'h0, SYNC_OUT_N});
        $display("test sync and reset done");
        stop_test();
    end
endmodule : conv_port_io_test
